// ===== logic/ata_cmd_pkg.sv
/*
 package for the command acceptance block: classes, result codes, timing, field layouts.
 assumes a 20 MHz core clock; task-file writes arrive as synchronous strobes.
*/
// Contract
// - class 1 command: busy set within 400 ns of opcode write
// - class 3: busy within 400 ns, drq within 20 ms, busy drops 400 ns later
// - read opcodes 20/21 40/41 22/23 c4 c8/c9 e4 ec are class 1
// - write opcodes 30/31 38 3c 32/33 ca/cb e8 50 are class 2
// - opcodes c5 and cd are class 3
// - opcodes 91 1x 7x ef c6 c0 90 03 87 f5 are class 1
// - power query is 98 or e5; other power opcodes are class 1
// - power query while asleep or in transition loads 00 into sector count
// - power query while idle loads ff into sector count
// - drive-only commands use drive bit and ignore head bits
// - diagnostic end places its code in the error register
// - diagnostic codes 01 02 03 04 05 and 8x
// - legacy erase and write-without-erase still erase the sectors
// - interrupts pass only while interrupt_disable_bit is zero
package ata_cmd_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BUSY_SET_NS = 400;
    localparam int unsigned BUSY_DROP_NS = 400;
    localparam int unsigned DRQ2_US = 700;
    localparam int unsigned DRQ3_MS = 20;
    // longest times round down
    localparam int unsigned DRQ2_CYC = DRQ2_US * (CLK_HZ / 1000000);
    localparam int unsigned DRQ3_CYC = DRQ3_MS * (CLK_HZ / 1000);
    localparam int unsigned BUSY_DROP_CYC = BUSY_DROP_NS * (CLK_HZ / 1000000) / 1000;
    localparam int unsigned CNT_W = 20;

    localparam logic [7:0] SC_ASLEEP = 8'h00;
    localparam logic [7:0] SC_IDLE = 8'hff;
    localparam logic [7:0] DIAG_OK = 8'h01;
    localparam logic [7:0] DIAG_SLAVE_FAIL = 8'h80;
    localparam int unsigned DH_DRIVE_BIT = 4;
    localparam int unsigned DH_HEAD_MSB = 3;
    localparam logic [7:0] SC_RESET = 8'h01;

    typedef enum logic [1:0] {CLS_NONE, CLS_1, CLS_2, CLS_3} cls_t;
    typedef enum logic [1:0] {PWR_IDLE, PWR_SLEEP, PWR_ENTER, PWR_WAKE} pwr_t;

    typedef struct packed {
        cls_t cls;
        logic pwr_query;
        logic diag;
        logic drive_only;
        logic legacy_erase;
        logic sleep_cmd;
    } decode_t;

    typedef struct packed {
        logic [7:0] sector_count_reg;
        logic [7:0] error;
        logic drive;
        logic [3:0] head;
    } taskfile_t;
endpackage

// ===== logic/ata_command_acceptance.sv
/*
 command acceptance: decodes an opcode write, runs busy/drq timing per class,
 answers the power-mode query and diagnostic, raises a gated interrupt.
 assumes the host waits for busy low and loads parameters before the opcode.
*/
module ata_command_acceptance (
    input wire logic i_core_clk, // 20 mhz core clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_cmd_wr, // one-cycle opcode write strobe
    input wire logic [7:0] i_opcode, // opcode written
    input wire logic [7:0] i_drive_head_select_reg, // drive/head register
    input wire logic i_interrupt_disable_bit, // 1 suppresses interrupt
    input wire logic [1:0] i_power_state, // current power state code
    input wire logic [7:0] i_diag_result, // diagnostic code from self test
    input wire logic i_cmd_done, // media side done: ends a class 1 command, or raises drq early for a class 2 or 3 write
    output logic o_busy, // status busy flag
    output logic o_drq, // data request
    output logic o_intrq, // interrupt request level
    output logic o_erase_req, // pulse: legacy erase of addressed sectors
    output logic o_sleep_req, // pulse: sleep opcode accepted
    output ata_cmd_pkg::taskfile_t o_tf, // sector count, error, drive, head
    output logic [7:0] o_active_opcode // opcode being executed
);
    typedef enum {ST_IDLE, ST_EXEC, ST_PREP, ST_DRQ, ST_FINISH} state_t;

    // sequencer state and the command captured at acceptance
    state_t state, next_state;
    logic [ata_cmd_pkg::CNT_W-1:0] cnt, next_cnt;
    ata_cmd_pkg::cls_t cls, next_cls;
    ata_cmd_pkg::decode_t dec, cur, next_cur;
    // next values of the registered outputs
    ata_cmd_pkg::taskfile_t next_tf;
    logic next_busy, next_drq, next_intrq, next_erase, next_sleep;
    logic [7:0] next_opcode;

    // opcode decode, purely combinational on the written value
    always_comb begin
        dec = '0;
        dec.drive_only = 1'b1;
        unique casez (i_opcode)
            // reads with full addressing use both drive and head
            8'h20, 8'h21, 8'h40, 8'h41, 8'h22, 8'h23, 8'hc4, 8'hc8, 8'hc9: begin
                dec.cls = ata_cmd_pkg::CLS_1;
                dec.drive_only = 1'b0;
            end
            8'he4, 8'hec: dec.cls = ata_cmd_pkg::CLS_1;
            // class 2 writes: buffer set up before the data request
            8'h30, 8'h31, 8'h32, 8'h33, 8'h3c, 8'hca, 8'hcb, 8'h50: begin
                dec.cls = ata_cmd_pkg::CLS_2;
                dec.drive_only = 1'b0;
            end
            8'h38: begin
                dec.cls = ata_cmd_pkg::CLS_2;
                dec.drive_only = 1'b0;
                dec.legacy_erase = 1'b1;
            end
            8'he8: dec.cls = ata_cmd_pkg::CLS_2;
            // class 3 multiple writes get the long buffer deadline
            8'hc5: begin
                dec.cls = ata_cmd_pkg::CLS_3;
                dec.drive_only = 1'b0;
            end
            8'hcd: begin
                dec.cls = ata_cmd_pkg::CLS_3;
                dec.drive_only = 1'b0;
                dec.legacy_erase = 1'b1;
            end
            // data-less class 1 commands with full addressing
            8'h91, 8'h7?, 8'h87, 8'hf5: begin
                dec.cls = ata_cmd_pkg::CLS_1;
                dec.drive_only = 1'b0;
            end
            // legacy sector erase still erases, with no speed gain
            8'hc0: begin
                dec.cls = ata_cmd_pkg::CLS_1;
                dec.drive_only = 1'b0;
                dec.legacy_erase = 1'b1;
            end
            8'h1?, 8'hef, 8'hc6, 8'h03: dec.cls = ata_cmd_pkg::CLS_1;
            // diagnostic copies the self-test code when it ends
            8'h90: begin
                dec.cls = ata_cmd_pkg::CLS_1;
                dec.diag = 1'b1;
            end
            // power-mode query answers from the power state input
            8'h98, 8'he5: begin
                dec.cls = ata_cmd_pkg::CLS_1;
                dec.pwr_query = 1'b1;
            end
            // sleep opcodes also tell the power logic to go to sleep
            8'he6, 8'h99: begin
                dec.cls = ata_cmd_pkg::CLS_1;
                dec.sleep_cmd = 1'b1;
            end
            8'he3, 8'h97, 8'he1, 8'h95, 8'he2, 8'h96, 8'he0, 8'h94:
                dec.cls = ata_cmd_pkg::CLS_1;
            default: dec.cls = ata_cmd_pkg::CLS_NONE; // unknown opcode: not accepted
        endcase
    end

    // sequencer next state; busy goes up the edge after the write (50 ns < 400 ns)
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cls = cls;
        next_cur = cur;
        next_tf = o_tf;
        next_busy = o_busy;
        next_drq = o_drq;
        next_intrq = o_intrq;
        next_erase = 1'b0;
        next_sleep = 1'b0;
        next_opcode = o_active_opcode;
        // the mask acts on the next edge, so a pending interrupt drops one cycle after the bit is set
        if (i_interrupt_disable_bit) begin
            next_intrq = 1'b0;
        end
        unique case (state)
            ST_IDLE: begin
                // any opcode write ends a pending data request, even an unknown one
                if (i_cmd_wr) begin
                    next_drq = 1'b0;
                end
                // a write while busy is ignored; the host must not issue one then
                if (i_cmd_wr && dec.cls != ata_cmd_pkg::CLS_NONE) begin
                    next_busy = 1'b1;
                    next_intrq = 1'b0;
                    next_cls = dec.cls;
                    next_cur = dec;
                    next_opcode = i_opcode;
                    next_cnt = '0;
                    next_tf.drive = i_drive_head_select_reg[ata_cmd_pkg::DH_DRIVE_BIT];
                    // drive-only commands keep the old head value
                    next_tf.head = dec.drive_only
                        ? o_tf.head
                        : i_drive_head_select_reg[ata_cmd_pkg::DH_HEAD_MSB:0];
                    next_erase = dec.legacy_erase;
                    next_sleep = dec.sleep_cmd;
                    next_state = (dec.cls == ata_cmd_pkg::CLS_1) ? ST_EXEC : ST_PREP;
                end
            end
            ST_EXEC: begin
                // query and diagnostic finish at once, the rest wait for the media
                if (cur.pwr_query) begin
                    if (i_power_state == 2'(ata_cmd_pkg::PWR_IDLE)) begin
                        next_tf.sector_count_reg = ata_cmd_pkg::SC_IDLE;
                    end else begin
                        next_tf.sector_count_reg = ata_cmd_pkg::SC_ASLEEP;
                    end
                    next_state = ST_FINISH;
                end else if (cur.diag) begin
                    next_tf.error = i_diag_result;
                    next_state = ST_FINISH;
                end else if (i_cmd_done) begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                // busy falls with the interrupt rising, so the host may poll or wait
                next_busy = 1'b0;
                next_intrq = ~i_interrupt_disable_bit;
                next_state = ST_IDLE;
            end
            ST_PREP: begin
                // buffer set up for the write; drq comes at the class deadline at most
                // an early media ready shortens the wait, the counter only bounds it
                next_cnt = cnt + 1'b1;
                if (i_cmd_done
                    || (cls == ata_cmd_pkg::CLS_2
                        && cnt == ata_cmd_pkg::CNT_W'(ata_cmd_pkg::DRQ2_CYC - 1))
                    || (cls == ata_cmd_pkg::CLS_3
                        && cnt == ata_cmd_pkg::CNT_W'(ata_cmd_pkg::DRQ3_CYC - 1))) begin
                    next_drq = 1'b1;
                    next_cnt = '0;
                    next_state = ST_DRQ;
                end
            end
            ST_DRQ: begin
                // busy falls a cycle after drq, well inside the drop window;
                // a slower media side would need a counter against the drop limit
                next_busy = 1'b0;
                next_state = ST_IDLE;
            end
        endcase
    end

    // drq clears on the next opcode write; data transfer lies outside this block
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // not busy, no request pending, diagnostic code reads no error
            state <= ST_IDLE;
            cnt <= '0;
            cls <= ata_cmd_pkg::CLS_NONE;
            cur <= '0;
            o_tf <= '{sector_count_reg: ata_cmd_pkg::SC_RESET, error: ata_cmd_pkg::DIAG_OK,
                      drive: 1'b0, head: 4'h0};
            o_busy <= 1'b0;
            o_drq <= 1'b0;
            o_intrq <= 1'b0;
            o_erase_req <= 1'b0;
            o_sleep_req <= 1'b0;
            o_active_opcode <= 8'h00;
        end else begin
            // register every next value; nothing is computed here
            state <= next_state;
            cnt <= next_cnt;
            cls <= next_cls;
            cur <= next_cur;
            o_tf <= next_tf;
            o_busy <= next_busy;
            o_drq <= next_drq;
            o_intrq <= next_intrq;
            o_erase_req <= next_erase;
            o_sleep_req <= next_sleep;
            o_active_opcode <= next_opcode;
        end
    end
endmodule // ata_command_acceptance

// ===== bench/ata_command_acceptance_props.sv
/* checker for the command acceptance block.
   assumes it is bound to the top module and sees only its ports. */
module ata_command_acceptance_props (
    input wire logic i_core_clk, // clock
    input wire logic i_rst_n, // reset
    input wire logic i_cmd_wr, // strobe
    input wire logic [7:0] i_opcode, // opcode
    input wire logic i_interrupt_disable_bit, // mask
    input wire logic [1:0] i_power_state, // power
    input wire logic [7:0] i_diag_result, // diag
    input wire logic o_busy, // busy
    input wire logic o_drq, // drq
    input wire logic o_intrq, // irq
    input wire logic o_erase_req, // erase
    input wire ata_cmd_pkg::taskfile_t o_tf // task file
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic take;
    logic query;
    // a write only counts while idle, so strobes under busy never qualify
    assign take = i_cmd_wr && !o_busy;
    assign query = take && (i_opcode == 8'he5 || i_opcode == 8'h98);
    a_busy_on_take: assert property (take && i_opcode == 8'h20 |-> ##[1:8] o_busy)
        else $error("busy late");
    a_query_idle_ff: assert property (query && i_power_state == 2'h0 |->
        ##2 o_tf.sector_count_reg == 8'hff)
        else $error("idle count wrong");
    a_query_sleep_00: assert property (query && i_power_state != 2'h0 |->
        ##2 o_tf.sector_count_reg == 8'h00)
        else $error("sleep count wrong");
    a_query_irq_end: assert property (query && !i_interrupt_disable_bit |->
        ##3 !o_busy && o_intrq)
        else $error("query end wrong");
    a_irq_masked: assert property (i_interrupt_disable_bit |=> !o_intrq)
        else $error("irq not masked");
    a_diag_code: assert property (take && i_opcode == 8'h90 |->
        ##2 o_tf.error == i_diag_result)
        else $error("diag code wrong");
    a_drq_busy_drop: assert property ($rose(o_drq) |=> !o_busy)
        else $error("busy stays after drq");
    a_erase_on_legacy: assert property (take
        && (i_opcode == 8'h38 || i_opcode == 8'hcd || i_opcode == 8'hc0) |-> ##[1:3] o_erase_req)
        else $error("no erase");
    a_erase_one_cycle: assert property (o_erase_req |=> !o_erase_req)
        else $error("erase too long");
    cover property (query);
    cover property ($rose(o_drq));
    cover property (take && i_opcode == 8'h90);
    cover property (o_erase_req);
endmodule // ata_command_acceptance_props

bind ata_command_acceptance ata_command_acceptance_props i_ata_command_acceptance_props (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_cmd_wr(i_cmd_wr), .i_opcode(i_opcode), .i_power_state(i_power_state),
    .i_interrupt_disable_bit(i_interrupt_disable_bit), .i_diag_result(i_diag_result),
    .o_busy(o_busy), .o_drq(o_drq), .o_intrq(o_intrq), .o_erase_req(o_erase_req), .o_tf(o_tf));

// ===== bench/ata_host_model.sv
/* host controller model: loads the drive/head register, then writes an opcode.
   assumes the core clock and the status busy flag of the block. */
module ata_host_model (
    input wire logic i_core_clk, // clock
    input wire logic i_busy, // status busy
    output logic o_cmd_wr, // opcode strobe
    output logic [7:0] o_opcode, // opcode bus
    output logic [7:0] o_drive_head_select_reg // parameter register
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cmd_wr = 1'b0;
        o_opcode = 8'h00;
        o_drive_head_select_reg = 8'h00;
    end
    // one command; the bus shows the inverse afterwards so stale data never matches
    task automatic issue(input logic [7:0] op, input logic [7:0] dh);
        int n;
        n = 0;
        @(posedge i_core_clk);
        #5;
        while (i_busy !== 1'b0 && n < 2000) begin
            @(posedge i_core_clk);
            #5;
            n++;
        end
        o_drive_head_select_reg = dh;
        @(posedge i_core_clk);
        #5;
        o_cmd_wr = 1'b1;
        o_opcode = op;
        @(posedge i_core_clk);
        #5;
        o_cmd_wr = 1'b0;
        o_opcode = ~op;
    endtask
endmodule // ata_host_model

// ===== bench/ata_command_acceptance_tb_top.sv
/* self-checking bench for the command acceptance block.
   assumes the host model issues opcodes and the bench plays the media side. */
module ata_command_acceptance_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, dis = 1'b0, done = 1'b0;
    logic cmd_wr, busy, drq, intrq, erase, sleep;
    logic [7:0] op, dh, act, diag = 8'h01;
    logic [1:0] ps = 2'h0;
    ata_cmd_pkg::taskfile_t tf;
    int error_cnt = 0, checked = 0, cyc = 0, erase_cnt = 0, sleep_cnt = 0;
    // data-less or read class 1 opcodes, then the write classes
    logic [7:0] c1 [30] = '{8'h20, 8'h21, 8'h40, 8'h41, 8'h22, 8'h23, 8'hc4, 8'hc8, 8'hc9,
        8'he4, 8'hec, 8'h91, 8'h1f, 8'h70, 8'hef, 8'hc6, 8'hc0, 8'h03, 8'h87, 8'hf5, 8'he3,
        8'h97, 8'he1, 8'h95, 8'he2, 8'h96, 8'he0, 8'h94, 8'he6, 8'h99};
    logic [7:0] cw [12] = '{8'h30, 8'h31, 8'h38, 8'h3c, 8'h32, 8'h33, 8'hca, 8'hcb, 8'he8,
        8'h50, 8'hc5, 8'hcd};
    always #25 clk = ~clk;
    ata_host_model i_ata_host_model (.i_core_clk(clk), .i_busy(busy), .o_cmd_wr(cmd_wr),
        .o_opcode(op), .o_drive_head_select_reg(dh));
    ata_command_acceptance i_ata_command_acceptance (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_cmd_wr(cmd_wr), .i_opcode(op), .i_drive_head_select_reg(dh),
        .i_interrupt_disable_bit(dis), .i_power_state(ps), .i_diag_result(diag),
        .i_cmd_done(done), .o_busy(busy), .o_drq(drq), .o_intrq(intrq), .o_erase_req(erase),
        .o_sleep_req(sleep), .o_tf(tf), .o_active_opcode(act));
    // pulse counters: the strobes are one cycle wide, so count them, each a single driver
    always @(posedge clk) if (erase === 1'b1) erase_cnt <= erase_cnt + 1;
    always @(posedge clk) if (sleep === 1'b1) sleep_cnt <= sleep_cnt + 1;
    task automatic check(input string s, input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wait_lvl(input bit d, input logic v, input int lim, input string s);
        int n;
        n = 0;
        while ((d ? drq : busy) !== v && n < lim) begin
            @(posedge clk);
            #5;
            n++;
        end
        check(s, {7'h0, d ? drq : busy}, {7'h0, v});
    endtask
    // m: 0 self-ending, 1 ended by media, 2 write with data request
    task automatic run(input logic [7:0] o, input logic [7:0] h, input int m);
        i_ata_host_model.issue(o, h);
        wait_lvl(0, 1'b1, 7, "busy set");
        if (m > 0) begin
            done = 1'b1;
            @(posedge clk);
            #5;
            done = 1'b0;
        end
        if (m == 2) wait_lvl(1, 1'b1, 8, "drq");
        wait_lvl(0, 1'b0, 8, "busy clear");
        if (m < 2) check("irq", {7'h0, intrq}, {7'h0, !dis});
    endtask
    task automatic t_query();
        for (int i = 0; i < 4; i++) begin
            ps = i[1:0];
            dis = i[0];
            run(i[1] ? 8'h98 : 8'he5, 8'h00, 0);
            check("count", tf.sector_count_reg, i == 0 ? 8'hff : 8'h00);
        end
        $display("t_query end");
    endtask
    task automatic t_diag();
        logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h83};
        dis = 1'b0;
        foreach (codes[i]) begin
            diag = codes[i];
            run(8'h90, 8'h00, 0);
            check("diag", tf.error, codes[i]);
        end
        $display("t_diag end");
    endtask
    task automatic t_class1();
        int e0;
        int s0;
        foreach (c1[i]) begin
            dis = i[0];
            e0 = erase_cnt;
            s0 = sleep_cnt;
            run(c1[i], 8'h00, 1);
            check("opcode", act, c1[i]);
            check("erase", 8'(erase_cnt - e0), {7'h0, c1[i] == 8'hc0});
            check("sleep", 8'(sleep_cnt - s0), {7'h0, c1[i] == 8'he6 || c1[i] == 8'h99});
        end
        dis = 1'b0;
        $display("t_class1 end");
    endtask
    task automatic t_head();
        run(8'h91, 8'h1a, 1);
        check("head", {3'h0, tf.drive, tf.head}, 8'h1a);
        run(8'hec, 8'h05, 1);
        check("drive only", {3'h0, tf.drive, tf.head}, 8'h0a);
        // an unknown opcode must leave busy and the active opcode alone
        i_ata_host_model.issue(8'h00, 8'h00);
        check("unknown busy", {7'h0, busy}, 8'h00);
        check("unknown opcode", act, 8'hec);
        $display("t_head end");
    endtask
    task automatic t_write();
        int e0;
        foreach (cw[i]) begin
            e0 = erase_cnt;
            run(cw[i], 8'h00, 2);
            check("drq stands", {7'h0, drq}, 8'h01);
            check("erase", 8'(erase_cnt - e0), {7'h0, cw[i] == 8'h38 || cw[i] == 8'hcd});
        end
        $display("t_write end");
    endtask
    // class 2 with no early media ready: drq must come by the deadline counter
    task automatic t_drq_wait();
        i_ata_host_model.issue(8'h30, 8'h00);
        check("drq cleared", {7'h0, drq}, 8'h00);
        wait_lvl(0, 1'b1, 7, "deadline busy set");
        wait_lvl(1, 1'b1, int'(ata_cmd_pkg::DRQ2_CYC), "drq deadline");
        wait_lvl(0, 1'b0, int'(ata_cmd_pkg::BUSY_DROP_CYC), "busy after drq");
        $display("t_drq_wait end");
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // the class 2 deadline wait dominates: about 14,300 cycles in all
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #5;
        rst_n = 1'b1;
        check("reset busy", {7'h0, busy}, 8'h00);
        check("reset irq", {7'h0, intrq}, 8'h00);
        t_query();
        t_diag();
        t_class1();
        t_head();
        t_write();
        t_drq_wait();
        finish_test();
    end
endmodule // ata_command_acceptance_tb_top
